// ---- common/vhl_pkg.sv ----
// shared constants and types for the connection lookup block
package vhl_pkg;
  // register offsets
  localparam logic [7:0] OFS_CTRL   = 8'h70;
  localparam logic [7:0] OFS_SBASE  = 8'h74;
  localparam logic [7:0] OFS_FBASE  = 8'h78;
  localparam logic [7:0] OFS_HBASE  = 8'h7C;
  localparam logic [7:0] OFS_QLEN   = 8'h80;
  localparam logic [7:0] OFS_STAT   = 8'h84;
  localparam logic [7:0] OFS_QBASE  = 8'h88;
  // reset values
  localparam logic [31:0] RST_REG   = 32'h0000_0000;
  // control register fields
  localparam int TAB_LSB            = 17;
  localparam int CACHE_BIT          = 0;
  localparam logic [3:0] TAB_MAX    = 4'hE;
  // hash bucket word positions
  localparam logic [22:0] BKT_HDR   = 23'h000001;
  localparam logic [22:0] BKT_CTRL  = 23'h000002;
  localparam logic [22:0] BKT_VCC   = 23'h000004;
  // word of the connection table holding the buffer address
  localparam logic [22:0] VCC_CBUF  = 23'h000001;
  // bucket control word fields and unknown count word field
  localparam int NEXT_W             = 23;
  localparam int MIDB_LSB           = 23;
  localparam int TYPE_LSB           = 27;
  localparam int CNT_LSB            = 16;
  localparam logic [3:0] MID_MAXB   = 4'hA;
  // queue entry sizes and fixed message queue span, in bytes
  localparam logic [4:0]  STQ_ENTRY = 5'h10;
  localparam logic [4:0]  FBQ_ENTRY = 5'h08;
  localparam logic [16:0] MSGQ_SPAN = 17'h00800;
  localparam int NUM_Q              = 5;

  typedef enum logic [1:0] {
    AAL_T5  = 2'h0,
    AAL_T0  = 2'h1,
    AAL_T34 = 2'h2,
    AAL_TRS = 2'h3
  } vhl_aal_t;

  typedef enum logic [3:0] {
    ST_IDLE = 4'h0,
    ST_HRD  = 4'h1,
    ST_MASK = 4'h3,
    ST_HDR  = 4'h2,
    ST_CTRL = 4'h6,
    ST_VCC  = 4'h7,
    ST_CBUF = 4'h5,
    ST_DONE = 4'h4,
    ST_CRD  = 4'hC,
    ST_CWR  = 4'hD
  } vhl_state_t;
endpackage : vhl_pkg

// ---- core/vhl_hash_index.sv ----
// hash index from cell header and table size
`timescale 1ns/100ps
module vhl_hash_index (
  input  wire logic [31:0] cell_hdr_i,
  input  wire logic [3:0]  tab_log2_i,
  output logic      [13:0] index_o
);
  logic [7:0]  vpi;
  logic [15:0] vci;
  logic [11:0] fold12;
  logic [13:0] fold14;
  logic [13:0] mask14;
  logic        wide;

  assign vpi    = cell_hdr_i[27:20];
  assign vci    = cell_hdr_i[19:4];
  assign fold12 = {vpi, vci[15:12]} ^ vci[11:0];
  assign fold14 = {vpi, vci[15:14], 4'h0} ^ vci[13:0];
  assign wide   = (tab_log2_i >= vhl_pkg::TAB_MAX);
  assign mask14 = 14'((15'h0001 << tab_log2_i) - 15'h0001);
  assign index_o = wide ? fold14 : ({2'h0, fold12} & mask14);
endmodule : vhl_hash_index

// ---- core/vhl_bucket_cmp.sv ----
// masked header compare and connection pointer slot selection
`timescale 1ns/100ps
module vhl_bucket_cmp (
  input  wire logic [31:0] mask_i,
  input  wire logic [31:0] bkt_hdr_i,
  input  wire logic [31:0] cell_hdr_i,
  input  wire logic [31:0] ctrl_i,
  input  wire logic [9:0]  mid_i,
  input  wire logic [22:0] bkt_ptr_i,
  output logic             match_o,
  output logic [1:0]       adaptation_type_o,
  output logic [22:0]      next_o,
  output logic [22:0]      vcc_slot_o
);
  logic [3:0]  mid_bits;
  logic [3:0]  bits_eff;
  logic [9:0]  mid_mask;
  logic [9:0]  mid_sel;

  assign match_o    = ((mask_i & cell_hdr_i) == bkt_hdr_i);
  assign adaptation_type_o = ctrl_i[vhl_pkg::TYPE_LSB +: 2];
  assign next_o     = ctrl_i[vhl_pkg::NEXT_W-1:0];
  assign mid_bits   = ctrl_i[vhl_pkg::MIDB_LSB +: 4];
  // codes above ten keep ten active bits
  assign bits_eff   = (mid_bits > vhl_pkg::MID_MAXB) ? vhl_pkg::MID_MAXB
                                                     : mid_bits;
  assign mid_mask   = 10'((11'h001 << bits_eff) - 11'h001);
  // only multiplexed connections step past the first slot
  assign mid_sel    = (adaptation_type_o == vhl_pkg::AAL_T34) ?
                      (mid_i & mid_mask) : 10'h000;
  assign vcc_slot_o = bkt_ptr_i + vhl_pkg::BKT_VCC
                    + {13'h0000, mid_sel};
endmodule : vhl_bucket_cmp

// ---- core/vhl_lookup.sv ----
// connection lookup engine with reassembly base registers
`timescale 1ns/100ps
////////////////////////////////////////////////////////////////////////////////
// Operation
// - index is {VPI[7:0],VCI[15:12]} xor VCI[11:0], masked by table size
// - index width runs from zero to fourteen bits
// - chain pointer read at hash base plus index times four
// - size fourteen uses {VPI,VCI[15:14],0000} xor VCI[13:0]
// - bucket matches when mask AND header equals bucket header word
// - on mismatch follow next pointer and compare again, in order
// - null next without match discards cell, bumps unknown count
// - AAL3/4 pointer at bucket base plus four plus masked MID
// - AAL5 uses first pointer; AAL3/4 one pointer per MID
// - AAL0 catch-all bucket matches unknown cells, reported as hits
// - status entries sixteen bytes, free entries eight, lengths configured
// - engine message queue fixed at 2048 bytes, no initialisation
// - sixteen-bit bases taken from registers 0x74 0x78 0x7C 0x88
// - matched connection table yields the current buffer address
// - adaptation type 00 AAL5, 01 AAL0, 10 AAL3/4
// - table size sits in control bits 20 to 17 at 0x70
// - table entries and next pointers are 23-bit word addresses
module vhl_lookup (
  input  wire logic        ref_clk_i,
  input  wire logic        rst_n_i,
  // register port
  input  wire logic [7:0]  reg_addr_i,
  input  wire logic [31:0] reg_wdata_i,
  input  wire logic        reg_wr_i,
  input  wire logic        reg_rd_i,
  output logic [31:0]      reg_rdata_o,
  // cell header in
  input  wire logic        hdr_valid_i,
  input  wire logic [31:0] hdr_i,
  input  wire logic [9:0]  mid_i,
  output logic             hdr_ready_o,
  // lookup answer
  output logic             res_valid_o,
  output logic             res_hit_o,
  output logic [1:0]       res_type_o,
  output logic [22:0]      res_conn_ptr_o,
  output logic [31:0]      res_cbuf_o,
  // local memory
  output logic             mem_req_o,
  output logic             mem_we_o,
  output logic [24:0]      mem_addr_o,
  output logic [31:0]      mem_wdata_o,
  input  wire logic        mem_ack_i,
  input  wire logic [31:0] mem_rdata_i,
  // queue area limits (byte address one past the end)
  output logic [16:0]      hstat_end_o,
  output logic [16:0]      lstat_end_o,
  output logic [16:0]      hfree_end_o,
  output logic [16:0]      lfree_end_o,
  output logic [16:0]      msgq_end_o
);
  ////////////////////////////////////////////////////////////////////////////
  // registers
  logic [31:0] ctrl_q, sbase_q, fbase_q, hbase_q, qbase_q, qlen_q;
  logic [31:0] rdata_q;
  logic [15:0] miss_tally_q;
  logic [3:0]  tab_log2;
  logic [31:0] rd_mux;
  logic        sel_ctrl, sel_sbase, sel_fbase, sel_hbase, sel_qbase;
  logic        sel_qlen, sel_stat;
  vhl_pkg::vhl_state_t state_q, state_d;

  assign tab_log2  = ctrl_q[vhl_pkg::TAB_LSB +: 4];
  assign sel_ctrl  = (reg_addr_i == vhl_pkg::OFS_CTRL);
  assign sel_sbase = (reg_addr_i == vhl_pkg::OFS_SBASE);
  assign sel_fbase = (reg_addr_i == vhl_pkg::OFS_FBASE);
  assign sel_hbase = (reg_addr_i == vhl_pkg::OFS_HBASE);
  assign sel_qbase = (reg_addr_i == vhl_pkg::OFS_QBASE);
  assign sel_qlen  = (reg_addr_i == vhl_pkg::OFS_QLEN);
  assign sel_stat  = (reg_addr_i == vhl_pkg::OFS_STAT);
  assign rd_mux = sel_ctrl  ? ctrl_q  : sel_sbase ? sbase_q :
                  sel_fbase ? fbase_q : sel_hbase ? hbase_q :
                  sel_qbase ? qbase_q : sel_qlen  ? qlen_q  :
                  sel_stat  ? {12'h000, state_q, miss_tally_q} :
                  32'h0000_0000;

  // cache bit is stored but has no effect on the lookup
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      ctrl_q  <= vhl_pkg::RST_REG;
      sbase_q <= vhl_pkg::RST_REG;
      fbase_q <= vhl_pkg::RST_REG;
      hbase_q <= vhl_pkg::RST_REG;
      qbase_q <= vhl_pkg::RST_REG;
      qlen_q  <= vhl_pkg::RST_REG;
      rdata_q <= vhl_pkg::RST_REG;
    end else begin
      if (reg_wr_i && sel_ctrl)  ctrl_q  <= reg_wdata_i;
      if (reg_wr_i && sel_sbase) sbase_q <= reg_wdata_i;
      if (reg_wr_i && sel_fbase) fbase_q <= reg_wdata_i;
      if (reg_wr_i && sel_hbase) hbase_q <= reg_wdata_i;
      if (reg_wr_i && sel_qbase) qbase_q <= reg_wdata_i;
      if (reg_wr_i && sel_qlen)  qlen_q  <= reg_wdata_i;
      if (reg_rd_i)              rdata_q <= rd_mux;
    end
  end
  assign reg_rdata_o = rdata_q;

  ////////////////////////////////////////////////////////////////////////////
  // queue area limits
  logic [15:0] q_base [vhl_pkg::NUM_Q];
  logic [16:0] q_span [vhl_pkg::NUM_Q];
  logic [16:0] q_end_q [vhl_pkg::NUM_Q];

  assign q_base[0] = sbase_q[15:0];
  assign q_base[1] = sbase_q[31:16];
  assign q_base[2] = fbase_q[15:0];
  assign q_base[3] = fbase_q[31:16];
  assign q_base[4] = qbase_q[15:0];
  assign q_span[0] = 17'(qlen_q[7:0]   * vhl_pkg::STQ_ENTRY);
  assign q_span[1] = 17'(qlen_q[15:8]  * vhl_pkg::STQ_ENTRY);
  assign q_span[2] = 17'(qlen_q[23:16] * vhl_pkg::FBQ_ENTRY);
  assign q_span[3] = 17'(qlen_q[31:24] * vhl_pkg::FBQ_ENTRY);
  assign q_span[4] = vhl_pkg::MSGQ_SPAN;

  for (genvar g = 0; g < vhl_pkg::NUM_Q; g++) begin : g_qend
    always_ff @(posedge ref_clk_i) begin
      if (!rst_n_i) q_end_q[g] <= 17'h00000;
      else          q_end_q[g] <= {1'b0, q_base[g]} + q_span[g];
    end
  end
  assign hstat_end_o = q_end_q[0];
  assign lstat_end_o = q_end_q[1];
  assign hfree_end_o = q_end_q[2];
  assign lfree_end_o = q_end_q[3];
  assign msgq_end_o  = q_end_q[4];

  ////////////////////////////////////////////////////////////////////////////
  // lookup datapath
  logic [31:0] cell_q, mask_q, bhdr_q, hash_src;
  logic [9:0]  mid_q;
  logic [22:0] ptr_q, conn_q;
  logic        match_q;
  logic [1:0]  type_q;
  logic [13:0] hidx;
  logic        cmp_match;
  logic [1:0]  cmp_type;
  logic [22:0] cmp_next, cmp_slot;
  logic [24:0] hash_addr, cnt_addr, addr_d;
  logic [14:0] tab_entries;
  logic [3:0]  tab_eff;
  logic        take_hdr, ack_hrd, ack_ctrl, req_d;

  vhl_hash_index u_hash (
    .cell_hdr_i (hash_src),
    .tab_log2_i (tab_log2),
    .index_o    (hidx)
  );

  vhl_bucket_cmp u_cmp (
    .mask_i     (mask_q),
    .bkt_hdr_i  (bhdr_q),
    .cell_hdr_i (cell_q),
    .ctrl_i     (mem_rdata_i),
    .mid_i      (mid_q),
    .bkt_ptr_i  (ptr_q),
    .match_o    (cmp_match),
    .adaptation_type_o (cmp_type),
    .next_o     (cmp_next),
    .vcc_slot_o (cmp_slot)
  );

  assign tab_eff     = (tab_log2 > vhl_pkg::TAB_MAX) ? vhl_pkg::TAB_MAX
                                                     : tab_log2;
  assign tab_entries = 15'h0001 << tab_eff;
  assign hash_addr   = {9'h000, hbase_q[15:0]} + {9'h000, hidx, 2'b00};
  assign cnt_addr    = {9'h000, hbase_q[15:0]}
                     + {8'h00, tab_entries, 2'b00};
  assign take_hdr    = hdr_valid_i && hdr_ready_o;
  // index the incoming header on the edge that takes it
  assign hash_src    = take_hdr ? hdr_i : cell_q;
  assign ack_hrd     = mem_ack_i && (state_q == vhl_pkg::ST_HRD);
  assign ack_ctrl    = mem_ack_i && (state_q == vhl_pkg::ST_CTRL);

  always_comb begin
    state_d = state_q;
    case (state_q)
      vhl_pkg::ST_IDLE: if (take_hdr) state_d = vhl_pkg::ST_HRD;
      vhl_pkg::ST_HRD: if (mem_ack_i) begin
        state_d = (mem_rdata_i[22:0] == 23'h0) ? vhl_pkg::ST_CRD
                                               : vhl_pkg::ST_MASK;
      end
      vhl_pkg::ST_MASK: if (mem_ack_i) state_d = vhl_pkg::ST_HDR;
      vhl_pkg::ST_HDR:  if (mem_ack_i) state_d = vhl_pkg::ST_CTRL;
      vhl_pkg::ST_CTRL: if (mem_ack_i) begin
        if (match_q)                 state_d = vhl_pkg::ST_VCC;
        else if (cmp_next == 23'h0)  state_d = vhl_pkg::ST_CRD;
        else                         state_d = vhl_pkg::ST_MASK;
      end
      vhl_pkg::ST_VCC:  if (mem_ack_i) state_d = vhl_pkg::ST_CBUF;
      vhl_pkg::ST_CBUF: if (mem_ack_i) state_d = vhl_pkg::ST_DONE;
      vhl_pkg::ST_CRD:  if (mem_ack_i) state_d = vhl_pkg::ST_CWR;
      vhl_pkg::ST_CWR:  if (mem_ack_i) state_d = vhl_pkg::ST_DONE;
      vhl_pkg::ST_DONE: state_d = vhl_pkg::ST_IDLE;
      default:          state_d = vhl_pkg::ST_IDLE;
    endcase
  end

  always_comb begin
    case (state_d)
      vhl_pkg::ST_HRD:  addr_d = hash_addr;
      vhl_pkg::ST_MASK: addr_d = {(ack_hrd ? mem_rdata_i[22:0]
                                  : ack_ctrl ? cmp_next : ptr_q), 2'b00};
      vhl_pkg::ST_HDR:  addr_d = {ptr_q + vhl_pkg::BKT_HDR, 2'b00};
      vhl_pkg::ST_CTRL: addr_d = {ptr_q + vhl_pkg::BKT_CTRL, 2'b00};
      vhl_pkg::ST_VCC:  addr_d = ack_ctrl ? {cmp_slot, 2'b00} : mem_addr_o;
      vhl_pkg::ST_CBUF: addr_d = (state_q == vhl_pkg::ST_VCC)
                        ? {mem_rdata_i[22:0] + vhl_pkg::VCC_CBUF, 2'b00}
                        : mem_addr_o;
      vhl_pkg::ST_CRD:  addr_d = cnt_addr;
      default:          addr_d = mem_addr_o;
    endcase
  end
  assign req_d = (state_d != vhl_pkg::ST_IDLE)
              && (state_d != vhl_pkg::ST_DONE);

  // memory request stays up across chained accesses, address moves on ack
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      state_q     <= vhl_pkg::ST_IDLE;
      mem_req_o   <= 1'b0;
      mem_we_o    <= 1'b0;
      mem_addr_o  <= 25'h0000000;
      mem_wdata_o <= 32'h0000_0000;
    end else begin
      state_q    <= state_d;
      mem_req_o  <= req_d;
      mem_addr_o <= addr_d;
      mem_we_o   <= (state_d == vhl_pkg::ST_CWR);
      if (state_q == vhl_pkg::ST_CRD && mem_ack_i)
        mem_wdata_o <= {mem_rdata_i[31:vhl_pkg::CNT_LSB] + 16'h0001,
                        mem_rdata_i[vhl_pkg::CNT_LSB-1:0]};
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      cell_q  <= 32'h0000_0000;
      mid_q   <= 10'h000;
      mask_q  <= 32'h0000_0000;
      bhdr_q  <= 32'h0000_0000;
      ptr_q   <= 23'h000000;
      conn_q  <= 23'h000000;
      match_q <= 1'b0;
      type_q  <= 2'h0;
    end else begin
      if (take_hdr) begin
        cell_q <= hdr_i;
        mid_q  <= mid_i;
      end
      if (ack_hrd) ptr_q <= mem_rdata_i[22:0];
      if (ack_ctrl && !match_q) ptr_q <= cmp_next;
      if (mem_ack_i && state_q == vhl_pkg::ST_MASK) mask_q <= mem_rdata_i;
      if (mem_ack_i && state_q == vhl_pkg::ST_HDR) begin
        bhdr_q  <= mem_rdata_i;
        match_q <= ((mask_q & cell_q) == mem_rdata_i);
      end
      if (ack_ctrl) type_q <= cmp_type;
      if (mem_ack_i && state_q == vhl_pkg::ST_VCC)
        conn_q <= mem_rdata_i[22:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // result
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      hdr_ready_o    <= 1'b0;
      res_valid_o    <= 1'b0;
      res_hit_o      <= 1'b0;
      res_type_o     <= 2'h0;
      res_conn_ptr_o <= 23'h000000;
      res_cbuf_o     <= 32'h0000_0000;
      miss_tally_q   <= 16'h0000;
    end else begin
      hdr_ready_o <= (state_d == vhl_pkg::ST_IDLE);
      res_valid_o <= (state_d == vhl_pkg::ST_DONE);
      if (mem_ack_i && state_q == vhl_pkg::ST_CBUF) begin
        res_hit_o      <= 1'b1;
        res_type_o     <= type_q;
        res_conn_ptr_o <= conn_q;
        res_cbuf_o     <= mem_rdata_i;
      end
      if (mem_ack_i && state_q == vhl_pkg::ST_CWR) begin
        res_hit_o      <= 1'b0;
        res_type_o     <= 2'h0;
        res_conn_ptr_o <= 23'h000000;
        res_cbuf_o     <= 32'h0000_0000;
        miss_tally_q   <= miss_tally_q + 16'h0001;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks
  sequence s_null_end;
    ack_ctrl && !match_q && (cmp_next == 23'h0);
  endsequence

  a_index_width: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    (tab_log2 < vhl_pkg::TAB_MAX) |-> ((hidx >> tab_log2) == 14'h0))
    else $error("hash index wider than table");
  a_hash_addr: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    (state_q == vhl_pkg::ST_HRD) |-> (mem_req_o && mem_addr_o ==
      {9'h000, hbase_q[15:0]} + {9'h000, hidx, 2'b00}))
    else $error("chain pointer address wrong");
  a_chain_next: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    (ack_ctrl && !match_q && cmp_next != 23'h0) |=>
      (state_q == vhl_pkg::ST_MASK && mem_addr_o == {$past(cmp_next), 2'b00}))
    else $error("chain not followed");
  a_null_miss: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    s_null_end |=> (state_q == vhl_pkg::ST_CRD) && mem_addr_o == cnt_addr)
    else $error("null next did not end search");
  a_count_bump: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    (state_q == vhl_pkg::ST_CRD && mem_ack_i) |=> mem_we_o &&
      mem_wdata_o[31:16] == $past(mem_rdata_i[31:16]) + 16'h0001)
    else $error("unknown count not bumped");
  a_mid_slot: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    (ack_ctrl && match_q) |=> mem_addr_o == {$past(cmp_slot), 2'b00})
    else $error("connection slot address wrong");
  a_aal5_slot: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    (ack_ctrl && match_q && cmp_type == vhl_pkg::AAL_T5) |=>
      mem_addr_o == {$past(ptr_q) + vhl_pkg::BKT_VCC, 2'b00})
    else $error("aal5 did not use first pointer");
  a_one_hdr: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    hdr_ready_o |-> (state_q == vhl_pkg::ST_IDLE))
    else $error("header accepted while busy");
  a_res_pulse: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    res_valid_o |=> !res_valid_o && hdr_ready_o)
    else $error("result not a single pulse");
endmodule : vhl_lookup

// ---- tb/vhl_mem_model.sv ----
// local memory partner answering the lookup engine's word accesses
`timescale 1ns/100ps
module vhl_mem_model (
  input  wire logic        ref_clk_i,
  input  wire logic        mem_req_i,
  input  wire logic        mem_we_i,
  input  wire logic [24:0] mem_addr_i,
  input  wire logic [31:0] mem_wdata_i,
  input  wire logic [3:0]  delay_i,
  output logic             mem_ack_o,
  output logic [31:0]      mem_rdata_o
);
  logic [31:0] mem [int];
  logic [3:0]  cnt_q;
  int          wa;
  initial begin
    mem_ack_o = 1'b0;
    mem_rdata_o = 32'h0000_0000;
    cnt_q = 4'h0;
  end
  assign wa = int'(mem_addr_i[24:2]);
  always @(posedge ref_clk_i) begin
    mem_ack_o <= 1'b0;
    // read data invalid outside the ack cycle
    mem_rdata_o <= ~mem_rdata_o;
    if (mem_req_i && !mem_ack_o) begin
      if (cnt_q == delay_i) begin
        cnt_q <= 4'h0;
        mem_ack_o <= 1'b1;
        if (mem_we_i) begin
          mem[wa] = mem_wdata_i;
        end else begin
          mem_rdata_o <= mem.exists(wa) ? mem[wa] : 32'h0000_0000;
        end
      end else begin
        cnt_q <= cnt_q + 4'h1;
      end
    end
  end
endmodule : vhl_mem_model

// ---- tb/testbench.sv ----
// self-checking bench for the connection lookup engine
`timescale 1ns/100ps
module testbench;
  localparam int HW = 32'h0000_2000;
  logic        ref_clk_i, rst_n_i, reg_wr, reg_rd, hdr_valid, hdr_ready;
  logic        res_valid, res_hit, mem_req, mem_we, mem_ack;
  logic [7:0]  reg_addr;
  logic [31:0] reg_wdata, reg_rdata, hdr, res_cbuf, mem_wdata, mem_rdata;
  logic [9:0]  mid;
  logic [1:0]  res_type;
  logic [22:0] res_ptr;
  logic [24:0] mem_addr;
  logic [16:0] hs_end, ls_end, hf_end, lf_end, mq_end;
  logic [3:0]  dly;
  int          num_errors, total_checks;

  vhl_lookup DUT (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i),
    .reg_addr_i(reg_addr), .reg_wdata_i(reg_wdata), .reg_wr_i(reg_wr),
    .reg_rd_i(reg_rd), .reg_rdata_o(reg_rdata), .hdr_valid_i(hdr_valid),
    .hdr_i(hdr), .mid_i(mid), .hdr_ready_o(hdr_ready),
    .res_valid_o(res_valid), .res_hit_o(res_hit), .res_type_o(res_type),
    .res_conn_ptr_o(res_ptr), .res_cbuf_o(res_cbuf), .mem_req_o(mem_req),
    .mem_we_o(mem_we), .mem_addr_o(mem_addr), .mem_wdata_o(mem_wdata),
    .mem_ack_i(mem_ack), .mem_rdata_i(mem_rdata), .hstat_end_o(hs_end),
    .lstat_end_o(ls_end), .hfree_end_o(hf_end), .lfree_end_o(lf_end),
    .msgq_end_o(mq_end));
  vhl_mem_model u_mem (.ref_clk_i(ref_clk_i), .mem_req_i(mem_req),
    .mem_we_i(mem_we), .mem_addr_i(mem_addr), .mem_wdata_i(mem_wdata),
    .delay_i(dly), .mem_ack_o(mem_ack), .mem_rdata_o(mem_rdata));

  initial begin
    ref_clk_i = 1'b0;
    forever #20 ref_clk_i = ~ref_clk_i;
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic stop_test;
    if (num_errors == 0 && total_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : stop_test
  task automatic check(string nm, logic [31:0] seen, logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check
  task automatic reg_write(logic [7:0] a, logic [31:0] d);
    @(posedge ref_clk_i);
    reg_wr <= 1'b1; reg_addr <= a; reg_wdata <= d;
    @(posedge ref_clk_i);
    reg_wr <= 1'b0;
  endtask : reg_write
  task automatic reg_check(logic [7:0] a, logic [31:0] e, logic [31:0] m);
    @(posedge ref_clk_i);
    reg_rd <= 1'b1; reg_addr <= a;
    @(posedge ref_clk_i);
    reg_rd <= 1'b0;
    @(negedge ref_clk_i);
    check($sformatf("reg %h", a), reg_rdata & m, e);
  endtask : reg_check
  function automatic logic [13:0] hidx(logic [31:0] h, int t);
    logic [7:0]  vp;
    logic [15:0] vc;
    vp = h[27:20];
    vc = h[19:4];
    if (t == 14) return {vp, vc[15:14], 4'h0} ^ vc[13:0];
    return 14'(({vp, vc[15:12]} ^ vc[11:0]) & ((1 << t) - 1));
  endfunction : hidx
  task automatic set_tab(logic [3:0] t);
    reg_write(vhl_pkg::OFS_CTRL, {11'h000, t, 17'h00000});
    reg_check(vhl_pkg::OFS_CTRL, {11'h000, t, 17'h00000}, '1);
  endtask : set_tab
  task automatic bkt(int p, logic [31:0] mk, logic [31:0] hd,
      logic [1:0] ty, logic [3:0] mb, logic [22:0] nx, logic [22:0] vc);
    u_mem.mem[p] = mk;
    u_mem.mem[p + 1] = hd;
    u_mem.mem[p + 2] = {3'h0, ty, mb, nx};
    u_mem.mem[p + 4] = 32'(vc);  // 20-byte bucket
  endtask : bkt
  task automatic lookup(logic [31:0] h, logic [9:0] m, logic eh,
      logic [1:0] et, logic [22:0] ep, logic [31:0] ec);
    int n;
    @(posedge ref_clk_i);
    hdr_valid <= 1'b1; hdr <= h; mid <= m;
    n = 0;
    do begin @(negedge ref_clk_i); n++; end
    while (hdr_ready !== 1'b1 && n < 100);
    @(posedge ref_clk_i);
    hdr_valid <= 1'b0;
    n = 0;
    do begin @(negedge ref_clk_i); n++; end
    while (res_valid !== 1'b1 && n < 500);
    check("res_valid", 32'(res_valid), 32'h1);
    check("hdr_ready", 32'(hdr_ready), 32'h0);
    check("res_hit", 32'(res_hit), 32'(eh));
    check("res_type", 32'(res_type), 32'(et));
    check("res_ptr", 32'(res_ptr), 32'(ep));
    check("res_cbuf", res_cbuf, ec);
  endtask : lookup
  function automatic logic [31:0] hh(logic [7:0] vp, logic [15:0] vc);
    return {4'h0, vp, vc, 4'h0};
  endfunction : hh
  ////////////////////////////////////////////////////////////////////////////
  task automatic t_regs;
    logic [7:0]  o [5] = '{8'h74, 8'h78, 8'h7C, 8'h80, 8'h88};
    logic [31:0] v [5] = '{32'h2000_1000, 32'h4000_3000, 32'h0000_8000,
                           32'h0408_0302, 32'h0000_5000};
    for (int i = 0; i < 5; i++) reg_check(o[i], vhl_pkg::RST_REG, '1);
    for (int i = 0; i < 5; i++) reg_write(o[i], v[i]);
    for (int i = 0; i < 5; i++) reg_check(o[i], v[i], '1);
    for (int w = 32'h400; w < 32'h80C; w++) u_mem.mem[w] = 32'h0;
    reg_write(vhl_pkg::OFS_STAT, 32'hFFFF_FFFF);
    reg_check(vhl_pkg::OFS_STAT, 32'h0000_0000, '1);
    reg_write(8'h90, 32'hFFFF_FFFF);
    reg_check(8'h90, 32'h0000_0000, '1);
    check("hs_end", 32'(hs_end), 32'h1020);
    check("ls_end", 32'(ls_end), 32'h2030);
    check("hf_end", 32'(hf_end), 32'h3040);
    check("lf_end", 32'(lf_end), 32'h4020);
    check("mq_end", 32'(mq_end), 32'h5800);
  endtask : t_regs
  task automatic t_tab0;
    logic [31:0] h;
    h = hh(8'h12, 16'h3456);
    set_tab(4'h0);
    u_mem.mem[HW] = 32'h170;
    bkt(32'h170, 32'hFFFF_FFF0, h & 32'hFFFF_FFF0, 2'h0, 4'h0, 0, 23'h340);
    u_mem.mem[32'h341] = 32'hBEEF_0000;
    lookup(h, 10'h0, 1'b1, 2'h0, 23'h340, 32'hBEEF_0000);
  endtask : t_tab0
  task automatic t_hit5;
    logic [31:0] h;
    h = hh(8'h12, 16'h3456);
    set_tab(4'h4);
    dly = 4'h3;
    u_mem.mem[HW + hidx(h, 4)] = 32'h100;
    bkt(32'h100, 32'hFFFF_FFF0, h & 32'hFFFF_FFF0, 2'h0, 4'h3, 0, 23'h300);
    u_mem.mem[32'h105] = 32'h3FF;
    u_mem.mem[32'h301] = 32'hCAFE_0001;
    lookup(h, 10'h3FF, 1'b1, 2'h0, 23'h300, 32'hCAFE_0001);
  endtask : t_hit5
  task automatic t_chain34;
    logic [31:0] h;
    h = hh(8'h12, 16'h3457);
    dly = 4'h1;
    u_mem.mem[HW + hidx(h, 4)] = 32'h110;
    bkt(32'h110, 32'hFFFF_FFFF, ~h, 2'h0, 4'h0, 23'h120, 23'h3FE);
    bkt(32'h120, 32'h0FFF_FFF0, h & 32'h0FFF_FFF0, 2'h2, 4'h4, 0, 23'h3FD);
    u_mem.mem[32'h129] = 32'h310;
    u_mem.mem[32'h311] = 32'h0000_1234;
    lookup(h, 10'h3A5, 1'b1, 2'h2, 23'h310, 32'h0000_1234);
  endtask : t_chain34
  task automatic t_miss;
    logic [31:0] h;
    h = hh(8'h12, 16'h3450);
    dly = 4'h0;
    u_mem.mem[HW + 16] = 32'h0005_1234;
    u_mem.mem[HW + hidx(h, 4)] = 32'h130;
    bkt(32'h130, 32'hFFFF_FFFF, ~h, 2'h0, 4'h0, 0, 23'h3FC);
    lookup(h, 10'h0, 1'b0, 2'h0, 23'h0, 32'h0);
    check("miss count", u_mem.mem[HW + 16] >> 16, 32'h6);
    h = hh(8'h12, 16'h3452);
    u_mem.mem[HW + hidx(h, 4)] = 32'h0;
    lookup(h, 10'h0, 1'b0, 2'h0, 23'h0, 32'h0);
    check("miss count", u_mem.mem[HW + 16] >> 16, 32'h7);
    reg_check(vhl_pkg::OFS_STAT, 32'h2, 32'hFFFF);
  endtask : t_miss
  task automatic t_catch;
    logic [31:0] h;
    h = hh(8'h12, 16'h3451);
    u_mem.mem[HW + hidx(h, 4)] = 32'h140;
    bkt(32'h140, 32'hFFFF_FFFF, ~h, 2'h0, 4'h0, 23'h150, 23'h3FB);
    bkt(32'h150, 32'h0, 32'h0, 2'h1, 4'h0, 0, 23'h320);
    u_mem.mem[32'h321] = 32'h0000_A0A0;
    lookup(h, 10'h0, 1'b1, 2'h1, 23'h320, 32'h0000_A0A0);
  endtask : t_catch
  task automatic t_tab14;
    logic [31:0] h;
    h = hh(8'hAB, 16'hCDEF);
    set_tab(4'hE);
    dly = 4'h2;
    u_mem.mem[HW + hidx(h, 14)] = 32'h160;
    bkt(32'h160, 32'hFFFF_FFF0, h & 32'hFFFF_FFF0, 2'h0, 4'h0, 0, 23'h330);
    u_mem.mem[32'h331] = 32'h0000_0055;
    lookup(h, 10'h0, 1'b1, 2'h0, 23'h330, 32'h0000_0055);
  endtask : t_tab14
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    num_errors = 0;
    total_checks = 0;
    rst_n_i = 1'b0;
    {reg_wr, reg_rd, hdr_valid, reg_addr, reg_wdata, hdr, mid} = '0;
    dly = 4'h0;
    repeat (8) @(posedge ref_clk_i);
    rst_n_i <= 1'b1;
    t_regs();
    t_tab0();
    t_hit5();
    t_chain34();
    t_miss();
    t_catch();
    t_tab14();
    stop_test();
  end
  initial begin
    #(40 * 20000);
    num_errors++;
    stop_test();
  end
endmodule : testbench
